// ===== bench/bsd_decode_sva.sv
// Port-level checks of the decoder's bus, fetch and power-down behaviour
`timescale 1ns/100ps
module bsd_decode_sva import bsd_pkg::*; (
  input wire logic                       core_clk_in,
  input wire logic                       nrst_in,
  input wire logic                       wb_cyc_in,
  input wire logic                       wb_stb_in,
  input wire logic                       wb_ack_out,
  input wire logic                       mem_req_out,
  input wire logic                       mem_we_out,
  input wire logic [1:0]                 mem_size_out,
  input wire logic [bsd_pkg::ADDR_W-1:0] mem_addr_out,
  input wire logic                       mem_ack_in,
  input wire logic                       wake_in,
  input wire logic                       sleep_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  AST_WB_ACK: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("register access not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_REQ_HOLD: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
    && $stable(mem_addr_out) && $stable(mem_we_out)) else $error("memory request moved");
  AST_REQ_GAP: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
    else $error("no idle cycle after memory answer");
  AST_FETCH_EVEN: assert property (mem_req_out && !mem_we_out && mem_size_out == SZ_WORD
    |-> !mem_addr_out[0]) else $error("word read at odd address");
  AST_MV_PAIR: assert property (mem_req_out && !mem_we_out && mem_size_out == SZ_BYTE
    && mem_ack_in |-> ##[1:8] (mem_req_out && mem_we_out && mem_size_out == SZ_BYTE))
    else $error("byte read not followed by byte write");
  AST_SLEEP_QUIET: assert property (sleep_out |-> !mem_req_out)
    else $error("memory access while powered down");
  AST_WAKE: assert property (wake_in [*6] |-> !sleep_out)
    else $error("wake did not leave power-down");
endmodule : bsd_decode_sva

// ===== bench/bsd_mem_model.sv
// Program and data memory answering the decoder's fetch and data port
`timescale 1ns/100ps
module bsd_mem_model (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             ack_out,
  output logic      [31:0] rdata_out
);
  logic [7:0] mem [0:1023];
  logic [9:0] a;
  logic [1:0] cnt;
  logic       slow;
  assign a = addr_in[9:0];
  // Big-endian bytes; latency alternates between prompt and slow answers
  always @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      ack_out   <= 1'b0;
      cnt       <= 2'h0;
      slow      <= 1'b0;
      rdata_out <= 32'h0;
    end
    else if (!ack_out && req_in && cnt == (slow ? 2'h2 : 2'h0))
    begin
      ack_out <= 1'b1;
      cnt     <= 2'h0;
      slow    <= ~slow;
      if (we_in)
        case (size_in)
          2'h0:    mem[a] <= wdata_in[7:0];
          2'h1:    {mem[a], mem[a+1]} <= wdata_in[15:0];
          default: {mem[a], mem[a+1], mem[a+2], mem[a+3]} <= wdata_in;
        endcase
      else
        rdata_out <= size_in == 2'h0 ? {24'h0, mem[a]} :
                     size_in == 2'h1 ? {16'h0, mem[a], mem[a+1]} :
                     {mem[a], mem[a+1], mem[a+2], mem[a+3]};
    end
    else
    begin
      ack_out   <= 1'b0;
      cnt       <= (req_in && !ack_out) ? cnt + 2'h1 : 2'h0;
      rdata_out <= ~rdata_out; // Data not held outside the answer cycle
    end
endmodule : bsd_mem_model

// ===== bench/tb_top.sv
// Self-checking bench: runs a short program through the decoder
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t value differs", $time); end end
module tb_top;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, wake = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, q;
  logic [15:0] prog [20] = '{16'h1005, 16'h110f, 16'h1208, 16'h1301, 16'h4702, 16'h1000,
    16'h4620, 16'h0000, 16'h602e, 16'h0500, 16'h0403, 16'h0100, 16'h0600, 16'h1880,
    16'h1d08, 16'h5000, 16'h0002, 16'h1000, 16'h7c30, 16'h40fe};
  wire         ack, req, mwe, mack, slp;
  wire  [1:0]  msz;
  wire  [23:0] madr;
  wire  [31:0] rdat, mwd, mrd;
  int          errors = 0, n_checks = 0;
  always #4 clk = ~clk;
  bsd_decode DUT (.core_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_ack_out(ack),
    .wb_dat_out(rdat), .mem_req_out(req), .mem_we_out(mwe), .mem_size_out(msz),
    .mem_addr_out(madr), .mem_wdata_out(mwd), .mem_ack_in(mack), .mem_rdata_in(mrd),
    .wake_in(wake), .sleep_out(slp));
  bsd_mem_model MEM (.clk_in(clk), .nrst_in(nrst), .req_in(req), .we_in(mwe),
    .size_in(msz), .addr_in(madr), .wdata_in(mwd), .ack_out(mack), .rdata_out(mrd));
  // One classic Wishbone cycle; request held until ack is seen at a rising edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task tally_and_finish;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hung core or bus
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    foreach (prog[i]) {MEM.mem[2*i], MEM.mem[2*i+1]} = prog[i];
    {MEM.mem[8'h40], MEM.mem[8'h41], MEM.mem[8'h50], MEM.mem[8'h51]} = 32'h0200_0300;
    {MEM.mem[8'h2c], MEM.mem[8'h2d], MEM.mem[8'h2e], MEM.mem[8'h2f]} = 32'h0000_0050;
    {MEM.mem[8'h30], MEM.mem[8'h31], MEM.mem[8'h32], MEM.mem[8'h33]} = 32'h0000_0040;
    {MEM.mem[10'h100], MEM.mem[10'h101]} = 16'haa55;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wb(8'h04, 1'b0, 32'h0);
    `CHK(q[0], 1'b1)
    wb(8'h30, 1'b1, 32'h2);
    wb(8'h34, 1'b1, 32'h100);
    wb(8'h38, 1'b1, 32'h180);
    wb(8'h3c, 1'b1, 32'h200);
    wb(8'h08, 1'b1, 32'h0);
    wb(8'h00, 1'b1, 32'h1);
    for (int i = 0; i < 3000 && slp !== 1'b1; i++) @(posedge clk);
    wb(8'h04, 1'b0, 32'h0);
    `CHK(q[1], 1'b1)
    wake <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(slp, 1'b0)
    wake <= 1'b0;
    repeat (100) @(posedge clk);
    wb(8'h00, 1'b1, 32'h0);
    repeat (30) @(posedge clk);
    wb(8'h08, 1'b0, 32'h0);
    `CHK(q[23:0], 24'h000026)
    wb(8'h0c, 1'b0, 32'h0);
    `CHK(q[15:0], 16'h800c)
    wb(8'h30, 1'b0, 32'h0);
    `CHK(q[7:0], 8'h00)
    wb(8'h34, 1'b0, 32'h0);
    `CHK(q, 32'h102)
    wb(8'h38, 1'b0, 32'h0);
    `CHK(q, 32'h182)
    wb(8'h3c, 1'b0, 32'h0);
    `CHK(q, 32'h200)
    wb(8'h20, 1'b0, 32'h0);
    `CHK(q, 32'h80)
    `CHK({MEM.mem[10'h1fe], MEM.mem[10'h1ff]}, 16'h0026)
    `CHK({MEM.mem[10'h180], MEM.mem[10'h181]}, 16'haa55)
    wb(8'h10, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    tally_and_finish();
  end
endmodule : tb_top
bind bsd_decode bsd_decode_sva SVA (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
  .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_size_out(mem_size_out),
  .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in), .wake_in(wake_in),
  .sleep_out(sleep_out));

// ===== src/bsd_branch_if.sv
// Link between the sequencer and the branch condition evaluator
`timescale 1ns/100ps
interface bsd_branch_if;
  logic [3:0]  cond;
  logic [7:0]  flags;
  logic [23:0] pc;
  logic [15:0] disp;
  logic        long_disp;
  logic        taken;
  logic [23:0] target;

  modport core (output cond, flags, pc, disp, long_disp, input taken, target);
  modport eval (input cond, flags, pc, disp, long_disp, output taken, target);
endinterface : bsd_branch_if

// ===== src/bsd_cond_eval.sv
// Branch condition evaluation and relative target formation
`timescale 1ns/100ps
module bsd_cond_eval (
  bsd_branch_if.eval br
);
  import bsd_pkg::*;

  logic c;
  logic v;
  logic z;
  logic n;

  assign c = br.flags[CCR_C];
  assign v = br.flags[CCR_V];
  assign z = br.flags[CCR_Z];
  assign n = br.flags[CCR_N];

  // Condition selected by the condition field
  always_comb
  begin
    case (br.cond)
      CC_T:    br.taken = 1'b1;
      CC_F:    br.taken = 1'b0;
      CC_HI:   br.taken = ~(c | z);
      CC_LS:   br.taken = c | z;
      CC_CC:   br.taken = ~c;
      CC_CS:   br.taken = c;
      CC_NE:   br.taken = ~z;
      CC_EQ:   br.taken = z;
      CC_VC:   br.taken = ~v;
      CC_VS:   br.taken = v;
      CC_PL:   br.taken = ~n;
      CC_MI:   br.taken = n;
      CC_GE:   br.taken = ~(n ^ v);
      CC_LT:   br.taken = n ^ v;
      CC_GT:   br.taken = ~(z | (n ^ v));
      default: br.taken = z | (n ^ v);
    endcase
  end

  // Sign-extended displacement added to the next-instruction address
  always_comb
  begin
    if (br.long_disp)
      br.target = br.pc + {{8{br.disp[15]}}, br.disp};
    else
      br.target = br.pc + {{16{br.disp[7]}}, br.disp[7:0]};
  end

endmodule : bsd_cond_eval

// ===== src/bsd_decode.sv
// Branch, system control and block move decode and sequencing unit
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

// Operation
// - Sixteen branch conditions from the four flags
// - Calls transfer control to the given address
// - Trap pushes state and enters vectored handling
// - Exception return restores flags and program counter
// - Sleep instruction enters the power-down state
// - Control loads and stores, memory word upper byte
// - And, or, xor immediate into control register
// - No-operation only advances program counter by two
// - Byte block move skips on zero count
// - Word block move uses sixteen-bit count
// - Next instruction starts right after last transfer
// - Instructions fetched as sixteen-bit units
// - Operation field in top four bits, maybe two
// - Three-bit address, three/four-bit data register fields
// - Extension word carries absolute address or displacement, never an immediate
// - Condition field picks the evaluated condition
// - Relative target is sign-extended displacement plus PC
// - Memory-indirect target read from zero-page byte address
// - Post-increment adds one, two or four
module bsd_decode (
  input  wire logic                          core_clk_in,
  input  wire logic                          nrst_in,
  input  wire logic                          wb_cyc_in,
  input  wire logic                          wb_stb_in,
  input  wire logic                          wb_we_in,
  input  wire logic [bsd_pkg::WB_ADR_W-1:0]  wb_adr_in,
  input  wire logic [3:0]                    wb_sel_in,
  input  wire logic [31:0]                   wb_dat_in,
  output logic                               wb_ack_out,
  output logic      [31:0]                   wb_dat_out,
  output logic                               mem_req_out,
  output logic                               mem_we_out,
  output logic      [1:0]                    mem_size_out,
  output logic      [bsd_pkg::ADDR_W-1:0]    mem_addr_out,
  output logic      [31:0]                   mem_wdata_out,
  input  wire logic                          mem_ack_in,
  input  wire logic [31:0]                   mem_rdata_in,
  input  wire logic                          wake_in,
  output logic                               sleep_out
);
  import bsd_pkg::*;

  typedef struct packed {
    bsd_state_type     state;
    logic              run;
    logic              unk;
    logic [ADDR_W-1:0] pc;
    logic [15:0]       ir;
    logic [15:0]       ext;
    logic [7:0]        condition_flags_register;
    logic [7:0]        extended_control_register;
    logic [7:0][31:0]  gr;
    logic [31:0]       wbuf;
    logic [ADDR_W-1:0] tmp;
    logic              mem_req;
    logic              mem_we;
    logic [1:0]        mem_size;
    logic [ADDR_W-1:0] mem_addr;
    logic [31:0]       mem_wdata;
    logic              wb_ack;
    logic [31:0]       wb_rdat;
    logic [2:0]        wake_sync;
    logic              sleep;
  } bsd_core_type;

  localparam bsd_core_type CORE_RST = '{state: ST_HALT, pc: PC_RST, condition_flags_register: CCR_RST,
                                        extended_control_register: EXR_RST, default: '0};

  bsd_core_type s;
  bsd_core_type n;
  logic [3:0]   op;
  logic [3:0]   sub;
  logic [2:0]   cfn;
  logic [7:0]   cur;
  logic         wake;
  logic [31:0]  wb_merge;

  bsd_branch_if br ();

  bsd_cond_eval u_eval (
    .br (br)
  );

  // Byte-lane merge for bus writes
  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction : merge_sel

  // Post-increment amount by access size
  function automatic logic [31:0] post_step(input logic [1:0] size);
    if (size == SZ_BYTE)
      return 32'h0000_0001;
    else if (size == SZ_WORD)
      return 32'h0000_0002;
    return 32'h0000_0004;
  endfunction : post_step

  // Whether an extension word follows the first word
  function automatic logic needs_ext(input logic [15:0] w);
    logic [3:0] o;
    o = w[15:12];
    return (o == OP_BCC16) || (o == OP_BSR && w[F_LONG_BIT])
           || (o == OP_JUMP && w[F_JM_LSB +: 2] == JM_ABS);
  endfunction : needs_ext

  // Transfer count of a block move
  function automatic logic [15:0] move_count(input logic [15:0] w, input logic [31:0] r4);
    if (w[11:8] == SYS_MOVB)
      return {8'h00, r4[7:0]};
    return r4[15:0];
  endfunction : move_count

  // Data register byte chosen by a four-bit field
  function automatic logic [7:0] dreg_byte(input logic [7:0][31:0] g, input logic [3:0] f);
    return f[F_DLOW_BIT] ? g[f[2:0]][7:0] : g[f[2:0]][15:8];
  endfunction : dreg_byte

  // Raise a memory request
  function automatic bsd_core_type issue(input bsd_core_type c, input logic we,
                                         input logic [1:0] size, input logic [ADDR_W-1:0] a,
                                         input logic [31:0] wd);
    bsd_core_type r;
    r           = c;
    r.mem_req   = 1'b1;
    r.mem_we    = we;
    r.mem_size  = size;
    r.mem_addr  = a;
    r.mem_wdata = wd;
    return r;
  endfunction : issue

  // Pre-decrement stack and queue a long push, then go to target (a trap instead reads its new PC from the target address)
  function automatic bsd_core_type enter_push(input bsd_core_type c, input logic [31:0] d,
                                              input logic [ADDR_W-1:0] tgt);
    bsd_core_type r;
    r                = c;
    r.gr[STACK_REG]  = c.gr[STACK_REG] - STACK_STEP;
    r.wbuf           = d;
    r.tmp            = tgt;
    r.state          = ST_PUSH;
    return r;
  endfunction : enter_push

  // Instruction field split and branch evaluator hookup
  assign op           = s.ir[15:12];
  assign sub          = s.ir[11:8];
  assign cfn          = s.ir[10:8];
  assign cur          = s.ir[F_EXR_BIT] ? s.extended_control_register : s.condition_flags_register;
  assign wake         = s.wake_sync[1] & s.wake_sync[2];
  assign br.cond      = (op == OP_BSR) ? CC_T : s.ir[11:8];
  assign br.flags     = s.condition_flags_register;
  assign br.pc        = s.pc;
  assign br.long_disp = (op == OP_BCC16) || (op == OP_BSR && s.ir[F_LONG_BIT]);
  assign br.disp      = br.long_disp ? s.ext : {8'h00, s.ir[7:0]};

  // Next-state logic: bus slave, then sequencer
  always_comb
  begin
    wb_merge    = 32'h0000_0000;
    n           = s;
    n.wake_sync = {s.wake_sync[1:0], wake_in};
    n.wb_ack    = 1'b0;
    if (wb_cyc_in && wb_stb_in && !s.wb_ack)
    begin
      n.wb_ack  = 1'b1;
      n.wb_rdat = 32'h0000_0000;
      if (wb_adr_in == REG_CTRL)
      begin
        n.wb_rdat = {31'h0, s.run};
        if (wb_we_in && wb_sel_in[0])
          n.run = wb_dat_in[0];
      end
      else if (wb_adr_in == REG_STATUS)
      begin
        n.wb_rdat = {24'h0, s.state, 1'b0, s.unk, s.state == ST_SLEEP, s.state == ST_HALT};
        if (wb_we_in && wb_sel_in[0] && wb_dat_in[2])
          n.unk = 1'b0;
      end
      else if (wb_adr_in == REG_PC)
      begin
        n.wb_rdat = {8'h00, s.pc};
        if (wb_we_in && s.state == ST_HALT)
        begin
          wb_merge = merge_sel({8'h00, s.pc}, wb_dat_in, wb_sel_in);
          n.pc     = wb_merge[ADDR_W-1:0];
        end
      end
      else if (wb_adr_in == REG_FLAGS)
      begin
        n.wb_rdat = {16'h0, s.extended_control_register, s.condition_flags_register};
        if (wb_we_in && s.state == ST_HALT)
        begin
          wb_merge       = merge_sel({16'h0, s.extended_control_register, s.condition_flags_register}, wb_dat_in, wb_sel_in);
          {n.extended_control_register, n.condition_flags_register} = wb_merge[15:0];
        end
      end
      else if (wb_adr_in[7:5] == REG_GR_HI && wb_adr_in[1:0] == 2'b00)
      begin
        n.wb_rdat = s.gr[wb_adr_in[4:2]];
        if (wb_we_in && s.state == ST_HALT)
          n.gr[wb_adr_in[4:2]] = merge_sel(s.gr[wb_adr_in[4:2]], wb_dat_in, wb_sel_in);
      end
    end

    case (s.state)
      ST_HALT:
        if (s.run)
          n.state = ST_FETCH;
      ST_FETCH:
        if (!s.mem_req)
        begin
          if (!s.run)
            n.state = ST_HALT;
          else
            n = issue(n, 1'b0, SZ_WORD, {s.pc[ADDR_W-1:1], 1'b0}, 32'h0);
        end
        else if (mem_ack_in)
        begin
          n.mem_req = 1'b0;
          n.ir      = mem_rdata_in[15:0];
          n.pc      = s.pc + PC_STEP;
          n.state   = needs_ext(mem_rdata_in[15:0]) ? ST_EXT : ST_EXEC;
        end
      ST_EXT:
        if (!s.mem_req)
          n = issue(n, 1'b0, SZ_WORD, {s.pc[ADDR_W-1:1], 1'b0}, 32'h0);
        else if (mem_ack_in)
        begin
          n.mem_req = 1'b0;
          n.ext     = mem_rdata_in[15:0];
          n.pc      = s.pc + PC_STEP;
          n.state   = ST_EXEC;
        end
      ST_EXEC:
      begin
        n.state = ST_FETCH;
        if (op == OP_BCC8 || op == OP_BCC16)
        begin
          if (br.taken)
            n.pc = br.target;
        end
        else if (op == OP_BSR)
          n = enter_push(n, {8'h00, s.pc}, br.target);
        else if (op == OP_JUMP)
        begin
          if (s.ir[F_JM_LSB +: 2] == JM_IND)
            n.state = ST_IND;
          else if (s.ir[F_JM_LSB +: 2] == JM_ABS && s.ir[F_JSUB_BIT])
            n = enter_push(n, {8'h00, s.pc}, {s.ir[7:0], s.ext});
          else if (s.ir[F_JM_LSB +: 2] == JM_ABS)
            n.pc = {s.ir[7:0], s.ext};
          else if (s.ir[F_JSUB_BIT])
            n = enter_push(n, {8'h00, s.pc}, s.gr[s.ir[6:4]][ADDR_W-1:0]);
          else
            n.pc = s.gr[s.ir[6:4]][ADDR_W-1:0];
        end
        else if (op == OP_SYS)
        begin
          if (sub == SYS_NOP)
            n.state = ST_FETCH;
          else if (sub == SYS_SLEEP)
            n.state = ST_SLEEP;
          else if (sub == SYS_RTS || sub == SYS_RTE)
            n.state = ST_POP;
          else if (sub == SYS_TRAP)
            n = enter_push(n, {s.condition_flags_register, s.pc}, TRAP_VEC_BASE + {20'h0, s.ir[1:0], 2'b00});
          else if (sub == SYS_MOVB || sub == SYS_MOVW)
            n.state = (move_count(s.ir, s.gr[COUNT_REG]) == 16'h0) ? ST_FETCH : ST_MV_RD;
          else
            n.unk = 1'b1;
        end
        else if (op == OP_CTRL)
        begin
          if (cfn == CF_LDM || cfn == CF_STM)
            n.state = ST_CTLMEM;
          else if (cfn == CF_STR && s.ir[F_DLOW_BIT])
            n.gr[s.ir[2:0]][7:0] = cur;
          else if (cfn == CF_STR)
            n.gr[s.ir[2:0]][15:8] = cur;
          else if (s.ir[F_EXR_BIT])
            n.extended_control_register = (cfn == CF_LDI) ? s.ir[7:0] : (cfn == CF_AND) ? (cur & s.ir[7:0]) :
                    (cfn == CF_OR) ? (cur | s.ir[7:0]) : (cfn == CF_XOR) ? (cur ^ s.ir[7:0]) :
                    dreg_byte(s.gr, s.ir[3:0]);
          else
            n.condition_flags_register = (cfn == CF_LDI) ? s.ir[7:0] : (cfn == CF_AND) ? (cur & s.ir[7:0]) :
                    (cfn == CF_OR) ? (cur | s.ir[7:0]) : (cfn == CF_XOR) ? (cur ^ s.ir[7:0]) :
                    dreg_byte(s.gr, s.ir[3:0]);
        end
        else
          n.unk = 1'b1;
      end
      ST_PUSH:
        if (!s.mem_req)
          n = issue(n, 1'b1, SZ_LONG, s.gr[STACK_REG][ADDR_W-1:0], s.wbuf);
        else if (mem_ack_in)
        begin
          n.mem_req = 1'b0;
          if (op == OP_SYS)
            n.state = ST_VEC;
          else
          begin
            n.pc    = s.tmp;
            n.state = ST_FETCH;
          end
        end
      ST_VEC:
        if (!s.mem_req)
          n = issue(n, 1'b0, SZ_LONG, s.tmp, 32'h0);
        else if (mem_ack_in)
        begin
          n.mem_req = 1'b0;
          n.pc      = mem_rdata_in[ADDR_W-1:0];
          n.state   = ST_FETCH;
        end
      ST_POP:
        if (!s.mem_req)
          n = issue(n, 1'b0, SZ_LONG, s.gr[STACK_REG][ADDR_W-1:0], 32'h0);
        else if (mem_ack_in)
        begin
          n.mem_req        = 1'b0;
          n.pc             = mem_rdata_in[ADDR_W-1:0];
          n.gr[STACK_REG]  = s.gr[STACK_REG] + post_step(SZ_LONG);
          n.state          = ST_FETCH;
          if (sub == SYS_RTE)
            n.condition_flags_register = mem_rdata_in[31:24];
        end
      ST_IND:
        if (!s.mem_req)
          n = issue(n, 1'b0, SZ_LONG, {16'h0000, s.ir[7:0]}, 32'h0);
        else if (mem_ack_in)
        begin
          n.mem_req = 1'b0;
          n.state   = ST_FETCH;
          if (s.ir[F_JSUB_BIT])
            n = enter_push(n, {8'h00, s.pc}, mem_rdata_in[ADDR_W-1:0]);
          else
            n.pc = mem_rdata_in[ADDR_W-1:0];
        end
      ST_CTLMEM:
        if (!s.mem_req)
          n = issue(n, cfn == CF_STM, SZ_WORD, s.gr[s.ir[6:4]][ADDR_W-1:0],
                    {16'h0000, cur, 8'h00});
        else if (mem_ack_in)
        begin
          n.mem_req = 1'b0;
          n.state   = ST_FETCH;
          if (cfn == CF_LDM && s.ir[F_EXR_BIT])
            n.extended_control_register = mem_rdata_in[15:8];
          else if (cfn == CF_LDM)
            n.condition_flags_register = mem_rdata_in[15:8];
        end
      ST_MV_RD:
        if (!s.mem_req)
          n = issue(n, 1'b0, SZ_BYTE, s.gr[SRC_REG][ADDR_W-1:0], 32'h0);
        else if (mem_ack_in)
        begin
          n.mem_req     = 1'b0;
          n.wbuf        = {24'h0, mem_rdata_in[7:0]};
          n.gr[SRC_REG] = s.gr[SRC_REG] + post_step(SZ_BYTE);
          n.state       = ST_MV_WR;
        end
      ST_MV_WR:
        if (!s.mem_req)
          n = issue(n, 1'b1, SZ_BYTE, s.gr[DST_REG][ADDR_W-1:0], s.wbuf);
        else if (mem_ack_in)
        begin
          n.mem_req     = 1'b0;
          n.gr[DST_REG] = s.gr[DST_REG] + post_step(SZ_BYTE);
          if (sub == SYS_MOVB)
            n.gr[COUNT_REG][7:0] = s.gr[COUNT_REG][7:0] - 8'h01;
          else
            n.gr[COUNT_REG][15:0] = s.gr[COUNT_REG][15:0] - 16'h0001;
          n.state = (move_count(s.ir, s.gr[COUNT_REG]) == 16'h0001) ? ST_FETCH
                                                                    : ST_MV_RD;
        end
      ST_SLEEP:
        if (wake)
          n.state = ST_FETCH;
      default:
        n.state = ST_HALT;
    endcase
    n.sleep = (n.state == ST_SLEEP);
  end

  // State register
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s <= CORE_RST;
    else
      s <= n;
  end

  // Outputs straight from state
  assign wb_ack_out    = s.wb_ack;
  assign wb_dat_out    = s.wb_rdat;
  assign mem_req_out   = s.mem_req;
  assign mem_we_out    = s.mem_we;
  assign mem_size_out  = s.mem_size;
  assign mem_addr_out  = s.mem_addr;
  assign mem_wdata_out = s.mem_wdata;
  assign sleep_out     = s.sleep;

endmodule : bsd_decode

// ===== src/bsd_pkg.sv
// Shared constants and types for the branch and system control decoder
package bsd_pkg;

  // Widths
  localparam int ADDR_W   = 24;
  localparam int WB_ADR_W = 8;

  // Flag register bit positions
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;

  // Instruction word field positions
  localparam int F_OP_LSB   = 12;
  localparam int F_SUB_LSB  = 8;
  localparam int F_EXR_BIT  = 11;
  localparam int F_JSUB_BIT = 11;
  localparam int F_JM_LSB   = 9;
  localparam int F_LONG_BIT = 8;
  localparam int F_AREG_LSB = 4;
  localparam int F_DLOW_BIT = 3;

  // First operation field
  localparam logic [3:0] OP_SYS   = 4'h0;
  localparam logic [3:0] OP_CTRL  = 4'h1;
  localparam logic [3:0] OP_BCC8  = 4'h4;
  localparam logic [3:0] OP_BCC16 = 4'h5;
  localparam logic [3:0] OP_BSR   = 4'h6;
  localparam logic [3:0] OP_JUMP  = 4'h7;

  // Second operation field of system group
  localparam logic [3:0] SYS_NOP   = 4'h0;
  localparam logic [3:0] SYS_SLEEP = 4'h1;
  localparam logic [3:0] SYS_RTS   = 4'h2;
  localparam logic [3:0] SYS_RTE   = 4'h3;
  localparam logic [3:0] SYS_TRAP  = 4'h4;
  localparam logic [3:0] SYS_MOVB  = 4'h5;
  localparam logic [3:0] SYS_MOVW  = 4'h6;

  // Second operation field of control-register group
  localparam logic [2:0] CF_LDI = 3'h0;
  localparam logic [2:0] CF_AND = 3'h1;
  localparam logic [2:0] CF_OR  = 3'h2;
  localparam logic [2:0] CF_XOR = 3'h3;
  localparam logic [2:0] CF_LDR = 3'h4;
  localparam logic [2:0] CF_STR = 3'h5;
  localparam logic [2:0] CF_LDM = 3'h6;
  localparam logic [2:0] CF_STM = 3'h7;

  // Jump target modes
  localparam logic [1:0] JM_REG = 2'h0;
  localparam logic [1:0] JM_ABS = 2'h1;
  localparam logic [1:0] JM_IND = 2'h2;

  // Branch condition codes
  localparam logic [3:0] CC_T  = 4'h0;
  localparam logic [3:0] CC_F  = 4'h1;
  localparam logic [3:0] CC_HI = 4'h2;
  localparam logic [3:0] CC_LS = 4'h3;
  localparam logic [3:0] CC_CC = 4'h4;
  localparam logic [3:0] CC_CS = 4'h5;
  localparam logic [3:0] CC_NE = 4'h6;
  localparam logic [3:0] CC_EQ = 4'h7;
  localparam logic [3:0] CC_VC = 4'h8;
  localparam logic [3:0] CC_VS = 4'h9;
  localparam logic [3:0] CC_PL = 4'ha;
  localparam logic [3:0] CC_MI = 4'hb;
  localparam logic [3:0] CC_GE = 4'hc;
  localparam logic [3:0] CC_LT = 4'hd;
  localparam logic [3:0] CC_GT = 4'he;
  localparam logic [3:0] CC_LE = 4'hf;

  // Memory access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Register map (byte addresses)
  localparam logic [WB_ADR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [WB_ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [WB_ADR_W-1:0] REG_PC     = 8'h08;
  localparam logic [WB_ADR_W-1:0] REG_FLAGS  = 8'h0c;
  localparam logic [2:0]          REG_GR_HI  = 3'h1;

  // Fixed general register roles
  localparam logic [2:0] COUNT_REG = 3'h4;
  localparam logic [2:0] SRC_REG   = 3'h5;
  localparam logic [2:0] DST_REG   = 3'h6;
  localparam logic [2:0] STACK_REG = 3'h7;

  // Steps, vectors and reset values
  localparam logic [ADDR_W-1:0] PC_STEP       = 24'h000002;
  localparam logic [ADDR_W-1:0] TRAP_VEC_BASE = 24'h000020;
  localparam logic [31:0]       STACK_STEP    = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] PC_RST        = 24'h000000;
  localparam logic [7:0]        CCR_RST       = 8'h00;
  localparam logic [7:0]        EXR_RST       = 8'h00;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_HALT, ST_FETCH, ST_EXT, ST_EXEC, ST_PUSH, ST_VEC,
    ST_POP, ST_IND, ST_CTLMEM, ST_MV_RD, ST_MV_WR, ST_SLEEP
  } bsd_state_type;

endpackage : bsd_pkg
